// File: design/scs_regs.svh
// Register offsets, field positions, reset values and limits for the SFD and preamble code selection block.
// Assumes a 32-bit APB bus; register files sit at byte address four times their index.
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// ***************************************************************
// Register indices and byte addresses
// ***************************************************************
`define SCS_IDX_CHAN_CTRL 8'h1f
`define SCS_IDX_RESERVED 8'h20
`define SCS_IDX_USER_SFD_LEN 8'h21
`define SCS_IDX_PATH_CONFIG 8'h22
`define SCS_IDX_PATH_STATUS 8'h23
`define SCS_ADDR_CHAN_CTRL 12'h07c
`define SCS_ADDR_RESERVED 12'h080
`define SCS_ADDR_USER_SFD_LEN 12'h084
`define SCS_ADDR_PATH_CONFIG 12'h088
`define SCS_ADDR_PATH_STATUS 12'h08c

// ***************************************************************
// Field positions in channel control
// ***************************************************************
`define SCS_BIT_VENDOR_SFD 17
`define SCS_BIT_TX_CUSTOM 20
`define SCS_BIT_RX_CUSTOM 21
`define SCS_TX_CODE_LSB 22
`define SCS_TX_CODE_MSB 26
`define SCS_RX_CODE_LSB 27
`define SCS_RX_CODE_MSB 31

// ***************************************************************
// Reset values and lengths
// ***************************************************************
`define SCS_RST_CHAN_CTRL 32'h0000_0000
`define SCS_RST_SFD_LEN 8'h08
`define SCS_RST_PATH_CONFIG 32'h0000_0000
`define SCS_SFD_LEN_MIN 8'h08
`define SCS_SFD_LEN_MAX 8'h10
`define SCS_SFD_LEN_SLOW 8'h40
`define SCS_SFD_LEN_STD_FAST 8'h08

`endif

// File: design/scs_pkg.sv
// Types shared by the SFD and preamble code selection block.
// Assumes scs_regs.svh defines the numeric constants.
`default_nettype none
package scs_pkg;
   // SFD source for one path
   typedef enum logic [1:0] {SCS_SFD_STANDARD, SCS_SFD_USER, SCS_SFD_VENDOR} scs_sfd_src_e;
   // APB request from master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } scs_apb_req_s;
   // APB answer to master
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } scs_apb_rsp_s;
   // Selection handed to one PHY path
   typedef struct packed {
      scs_sfd_src_e src;
      logic [7:0] sfd_len;
      logic [4:0] preamble_code;
   } scs_path_sel_s;
endpackage
`default_nettype wire

// File: design/scs_path_sel.sv
// One path's SFD source and length resolver.
// Assumes synchronous inputs in the ref_clk domain; outputs registered.
`include "scs_regs.svh"
`default_nettype none
module scs_path_sel
   import scs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic custom_en,
   input wire logic vendor_en,
   input wire logic rate_110k,
   input wire logic [7:0] user_len,
   input wire logic [4:0] code_in,
   output scs_pkg::scs_path_sel_s sel
);
   import scs_pkg::*;

   // ***************************************************************
   // Source and length decode
   // ***************************************************************
   // Vendor beats custom, custom beats standard
   wire scs_sfd_src_e src_w = vendor_en ? SCS_SFD_VENDOR : // [RQ11]
                              custom_en ? SCS_SFD_USER :   // [RQ2] [RQ4]
                              SCS_SFD_STANDARD;            // [RQ1] [RQ3]
   // Out-of-range user length clamps, so the PHY never sees a bad count
   wire logic [7:0] clamp_len = (user_len < `SCS_SFD_LEN_MIN) ? `SCS_SFD_LEN_MIN :
                                (user_len > `SCS_SFD_LEN_MAX) ? `SCS_SFD_LEN_MAX : user_len;
   // Slow rate always 64 symbols
   wire logic [7:0] len_w = rate_110k ? `SCS_SFD_LEN_SLOW :            // [RQ10]
                            (src_w == SCS_SFD_STANDARD) ? `SCS_SFD_LEN_STD_FAST :
                            clamp_len;                                  // [RQ9]
   scs_path_sel_s sel_d;
   scs_path_sel_s sel_q;
   assign sel_d = '{src: src_w, sfd_len: len_w, preamble_code: code_in};
   assign sel = sel_q;

   // Output register
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sel_q <= '{src: SCS_SFD_STANDARD, sfd_len: `SCS_SFD_LEN_STD_FAST, preamble_code: 5'h00};
      end
      else
      begin
         sel_q <= sel_d;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   a_vendor_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
      vendor_en |=> sel_q.src == SCS_SFD_VENDOR) else $error("vendor SFD not chosen"); // [RQ11]
   a_slow_len: assert property (@(posedge ref_clk) disable iff (!rstn)
      rate_110k |=> sel_q.sfd_len == 8'h40) else $error("slow rate SFD not 64"); // [RQ10]
   a_fast_len: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!rate_110k && custom_en && !vendor_en) |=> (sel_q.sfd_len >= 8'h08 && sel_q.sfd_len <= 8'h10))
      else $error("user Custom_sfd_len out of range"); // [RQ9]
endmodule
`default_nettype wire

// File: design/scs_top.sv
// Behaviour
// (RQ1) TX standard SFD when custom, vendor clear
// (RQ2) TX custom bit selects user SFD table
// (RQ3) RX hunts standard SFD when both clear
// (RQ4) RX custom bit selects user SFD table
// (RQ5) Far end must use matching SFD
// (RQ6) Bits 26:22 select TX preamble code
// (RQ7) Bits 31:27 select RX preamble code
// (RQ8) Software never writes reserved slot 0x20
// (RQ9) Custom Custom_sfd_len 8 to 16 otherwise
// (RQ10) At 110 kbps SFD is 64 symbols
// (RQ11) Vendor SFD enable overrides both custom bits
//
// APB register bank choosing SFD source and preamble codes per path.
// Assumes single ref_clk, inputs synchronous, PHY consumes the path outputs.
//
// Implementation choice: register access over APB.
`include "scs_regs.svh"
`default_nettype none
module scs_top
   import scs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire scs_pkg::scs_apb_req_s apb_req,
   output scs_pkg::scs_apb_rsp_s apb_rsp,
   output scs_pkg::scs_path_sel_s tx_sel,
   output scs_pkg::scs_path_sel_s rx_sel
);
   import scs_pkg::*;

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [31:0] chan_ctrl_q; // Channel control word
   logic [7:0] sfd_len_q; // User Custom_sfd_len
   logic [31:0] path_cfg_q; // Bit 0 selects 110 kbps rate
   logic reserved_hit_q; // Sticky: reserved slot was written
   logic [31:0] prdata_q; // Registered read data
   logic pslverr_q;

   // ***************************************************************
   // Address decode
   // ***************************************************************
   wire logic setup = apb_req.psel && !apb_req.penable;
   wire logic hit_ctrl = apb_req.paddr == `SCS_ADDR_CHAN_CTRL;
   wire logic hit_rsv = apb_req.paddr == `SCS_ADDR_RESERVED;
   wire logic hit_len = apb_req.paddr == `SCS_ADDR_USER_SFD_LEN;
   wire logic hit_cfg = apb_req.paddr == `SCS_ADDR_PATH_CONFIG;
   wire logic hit_sts = apb_req.paddr == `SCS_ADDR_PATH_STATUS;
   wire logic mapped = hit_ctrl || hit_rsv || hit_len || hit_cfg || hit_sts;
   // Reserved slot has no function; a write is refused, not stored
   wire logic bad_wr = apb_req.pwrite && (hit_rsv || hit_sts); // [RQ8]
   wire logic err_d = !mapped || bad_wr;
   // Write takes effect on the access edge only
   wire logic wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && !pslverr_q;
   wire logic rate_110k = path_cfg_q[0];

   // Byte lane merge
   function automatic logic [31:0] scs_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   wire logic [31:0] ctrl_merged = scs_merge(chan_ctrl_q, apb_req.pwdata, apb_req.pstrb);
   wire logic [31:0] len_merged = scs_merge({24'h0, sfd_len_q}, apb_req.pwdata, apb_req.pstrb);
   wire logic [31:0] cfg_merged = scs_merge(path_cfg_q, apb_req.pwdata, apb_req.pstrb);

   // Status word: sources, rate and reserved-write flag
   wire logic [31:0] status_w = {26'h0, reserved_hit_q, rate_110k, rx_sel.src, tx_sel.src};
   wire logic [31:0] rdata_d = hit_ctrl ? chan_ctrl_q :
                               hit_len ? {24'h0, sfd_len_q} :
                               hit_cfg ? path_cfg_q :
                               hit_sts ? status_w : 32'h0;

   // ***************************************************************
   // Setup phase capture of read data and error
   // ***************************************************************
   // No wait state: answer is prepared in setup, given in the first access cycle
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end
      else if (setup)
      begin
         prdata_q <= apb_req.pwrite ? 32'h0 : rdata_d;
         pslverr_q <= err_d;
      end
   end

   // Control writes
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         chan_ctrl_q <= `SCS_RST_CHAN_CTRL;
         sfd_len_q <= `SCS_RST_SFD_LEN;
         path_cfg_q <= `SCS_RST_PATH_CONFIG;
      end
      else if (wr_en)
      begin
         if (hit_ctrl)
         begin
            chan_ctrl_q <= ctrl_merged; // [RQ6] [RQ7]
         end
         if (hit_len)
         begin
            sfd_len_q <= len_merged[7:0];
         end
         if (hit_cfg)
         begin
            path_cfg_q <= {31'h0, cfg_merged[0]};
         end
      end
   end

   // Sticky flag records a refused reserved write; reading status clears none
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         reserved_hit_q <= 1'b0;
      end
      else if (apb_req.psel && apb_req.penable && apb_req.pwrite && hit_rsv)
      begin
         reserved_hit_q <= 1'b1; // [RQ8]
      end
   end

   assign apb_rsp = '{pready: apb_req.psel && apb_req.penable,
                      pslverr: apb_req.psel && apb_req.penable && pslverr_q,
                      prdata: prdata_q};

   // ***************************************************************
   // Path resolvers
   // ***************************************************************
   // Matching SFD with the far end is software's duty, not checked here [RQ5]
   scs_path_sel #() u_tx (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .custom_en(chan_ctrl_q[`SCS_BIT_TX_CUSTOM]),
      .vendor_en(chan_ctrl_q[`SCS_BIT_VENDOR_SFD]),
      .rate_110k(rate_110k),
      .user_len(sfd_len_q),
      .code_in(chan_ctrl_q[`SCS_TX_CODE_MSB:`SCS_TX_CODE_LSB]), // [RQ6]
      .sel(tx_sel)
   );
   scs_path_sel #() u_rx (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .custom_en(chan_ctrl_q[`SCS_BIT_RX_CUSTOM]),
      .vendor_en(chan_ctrl_q[`SCS_BIT_VENDOR_SFD]),
      .rate_110k(rate_110k),
      .user_len(sfd_len_q),
      .code_in(chan_ctrl_q[`SCS_RX_CODE_MSB:`SCS_RX_CODE_LSB]), // [RQ7]
      .sel(rx_sel)
   );

   // ***************************************************************
   // Checks
   // ***************************************************************
   a_tx_standard: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!chan_ctrl_q[20] && !chan_ctrl_q[17]) |=> tx_sel.src == SCS_SFD_STANDARD)
      else $error("tx not standard SFD"); // [RQ1]
   a_tx_user: assert property (@(posedge ref_clk) disable iff (!rstn)
      (chan_ctrl_q[20] && !chan_ctrl_q[17]) |=> tx_sel.src == SCS_SFD_USER)
      else $error("tx not user SFD"); // [RQ2]
   a_rx_standard: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!chan_ctrl_q[21] && !chan_ctrl_q[17]) |=> rx_sel.src == SCS_SFD_STANDARD)
      else $error("rx not standard SFD"); // [RQ3]
   a_rx_user: assert property (@(posedge ref_clk) disable iff (!rstn)
      (chan_ctrl_q[21] && !chan_ctrl_q[17]) |=> rx_sel.src == SCS_SFD_USER)
      else $error("rx not user SFD"); // [RQ4]
   a_tx_code_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
      (wr_en && hit_ctrl && apb_req.pstrb == 4'hf) |=> ##1 tx_sel.preamble_code == $past(apb_req.pwdata[26:22], 2))
      else $error("tx code mismatch"); // [RQ6]
   a_rx_code_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
      (wr_en && hit_ctrl && apb_req.pstrb == 4'hf) |=> ##1 rx_sel.preamble_code == $past(apb_req.pwdata[31:27], 2))
      else $error("rx code mismatch"); // [RQ7]
   a_reserved_refused: assert property (@(posedge ref_clk) disable iff (!rstn)
      (apb_req.psel && apb_req.penable && apb_req.pwrite && hit_rsv) |-> apb_rsp.pslverr && $stable(chan_ctrl_q))
      else $error("reserved write not refused"); // [RQ8]
   a_vendor_both: assert property (@(posedge ref_clk) disable iff (!rstn)
      chan_ctrl_q[17] |=> (tx_sel.src == SCS_SFD_VENDOR && rx_sel.src == SCS_SFD_VENDOR))
      else $error("vendor SFD not on both paths"); // [RQ11]
endmodule
`default_nettype wire

// File: test/scs_remote_xcvr.sv
// Remote transceiver model: far end of the air link.
// Assumes it sees the block's path selections directly.
`default_nettype none
module scs_remote_xcvr
   import scs_pkg::*;
(
   input wire scs_pkg::scs_path_sel_s local_tx,
   input wire scs_pkg::scs_path_sel_s local_rx,
   input wire scs_pkg::scs_sfd_src_e far_src,
   input wire logic [4:0] far_code,
   output logic far_hears,
   output logic near_hears
);
   timeunit 1ns;
   timeprecision 1ps;
   import scs_pkg::*;
   // ***************************************************************
   // Link matching
   // ***************************************************************
   // Far receiver hunts only its own SFD and code
   assign far_hears = (local_tx.src == far_src) && (local_tx.preamble_code == far_code);
   // Far transmitter sends the setting it hunts for
   assign near_hears = (local_rx.src == far_src) && (local_rx.preamble_code == far_code);
endmodule
`default_nettype wire

// File: test/sfd_and_preamble_code_select_test.sv
// Self-checking bench for the SFD and preamble code register bank.
// Assumes zero-wait APB and selections two edges after a write.
`include "scs_regs.svh"
`default_nettype none
module sfd_and_preamble_code_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   import scs_pkg::*;
   logic ref_clk, rstn, far_hears, near_hears;
   scs_apb_req_s apb_req; // Master request
   scs_apb_rsp_s apb_rsp; // Slave answer
   scs_path_sel_s tx_sel, rx_sel; // Path selections
   scs_sfd_src_e far_src, ts, rs; // Far and expected sources
   logic [4:0] far_code;
   logic [33:0] q[$]; // Expected {error-free read, err, data}
   logic [31:0] seed = 32'h1761, d, w;
   logic [7:0] ul; // User Custom_sfd_len written
   logic [3:0] strb = 4'hf; // Byte lanes of the next transfer
   int n_mismatch = 0, num_checks = 0;
   scs_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .tx_sel(tx_sel), .rx_sel(rx_sel));
   scs_remote_xcvr u_far (.local_tx(tx_sel), .local_rx(rx_sel), .far_src(far_src),
      .far_code(far_code), .far_hears(far_hears), .near_hears(near_hears));
   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected Custom_sfd_len; fast rates clamp the user value
   function automatic logic [7:0] el(scs_sfd_src_e s, logic slow, logic [7:0] u);
      if (slow) return `SCS_SFD_LEN_SLOW;
      if (s == SCS_SFD_STANDARD) return `SCS_SFD_LEN_STD_FAST;
      if (u < `SCS_SFD_LEN_MIN) return `SCS_SFD_LEN_MIN;
      if (u > `SCS_SFD_LEN_MAX) return `SCS_SFD_LEN_MAX;
      return u;
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_sel(string nm, scs_path_sel_s g, scs_sfd_src_e s, logic [7:0] l, logic [4:0] c);
      chk({nm, " src"}, 32'(s), 32'(g.src));
      chk({nm, " len"}, 32'(l), 32'(g.sfd_len));
      chk({nm, " code"}, 32'(c), 32'(g.preamble_code));
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One APB transfer; the answer is noted for the monitor
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, logic e, logic [31:0] x);
      int n;
      q.push_back({~wr & ~e, e, x});
      @(posedge ref_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd, pstrb: strb};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      // Hold until pready is sampled high
      for (n = 0; n < 50; n++)
      begin
         @(posedge ref_clk);
         if (apb_rsp.pready === 1'b1) break;
      end
      if (n == 50)
      begin
         n_mismatch++;
         final_report();
      end
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   // ***************************************************************
   // Clock, monitor and watchdog
   // ***************************************************************
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Oldest note against each completed transfer
   always @(posedge ref_clk)
   begin
      if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1)
      begin
         if (q.size() == 0)
            chk("queue", 32'h1, 32'h0);
         else
         begin
            chk("pslverr", 32'(q[0][32]), 32'(apb_rsp.pslverr));
            if (q[0][33]) chk("prdata", q[0][31:0], apb_rsp.prdata);
            void'(q.pop_front());
         end
      end
   end
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      final_report();
   end
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      rstn = 1'b0;
      apb_req = '0;
      far_src = SCS_SFD_STANDARD;
      far_code = 5'h00;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      chk_sel("tx", tx_sel, SCS_SFD_STANDARD, 8'h08, 5'h00);
      chk_sel("rx", rx_sel, SCS_SFD_STANDARD, 8'h08, 5'h00);
      apb(1'b0, `SCS_ADDR_CHAN_CTRL, 32'h0, 1'b0, `SCS_RST_CHAN_CTRL);
      apb(1'b0, `SCS_ADDR_USER_SFD_LEN, 32'h0, 1'b0, {24'h0, `SCS_RST_SFD_LEN});
      // Every enable and rate combination, random codes and length
      for (int i = 0; i < 16; i++)
      begin
         d = xs();
         d[21:20] = 2'(i);
         d[17] = i[2];
         ul = {3'h0, 5'(xs())};
         apb(1'b1, `SCS_ADDR_USER_SFD_LEN, {24'h0, ul}, 1'b0, 32'h0);
         apb(1'b1, `SCS_ADDR_PATH_CONFIG, {31'h0, i[3]}, 1'b0, 32'h0);
         apb(1'b1, `SCS_ADDR_CHAN_CTRL, d, 1'b0, 32'h0);
         apb(1'b0, `SCS_ADDR_CHAN_CTRL, 32'h0, 1'b0, d);
         repeat (3) @(posedge ref_clk);
         // Vendor enable wins over both custom bits
         ts = d[17] ? SCS_SFD_VENDOR : (d[20] ? SCS_SFD_USER : SCS_SFD_STANDARD);
         rs = d[17] ? SCS_SFD_VENDOR : (d[21] ? SCS_SFD_USER : SCS_SFD_STANDARD);
         chk_sel("tx", tx_sel, ts, el(ts, i[3], ul), d[26:22]);
         chk_sel("rx", rx_sel, rs, el(rs, i[3], ul), d[31:27]);
         far_src <= ts;
         far_code <= d[26:22];
         @(posedge ref_clk);
         chk("far_hears", 32'h1, 32'(far_hears));
         chk("near_hears", 32'(rs == ts && d[31:27] == d[26:22]), 32'(near_hears));
         apb(1'b0, `SCS_ADDR_PATH_STATUS, 32'h0, 1'b0, {26'h0, 1'b0, i[3], rs, ts});
      end
      // Upper lanes only: the low half of the control word must survive
      strb = 4'hc;
      w = xs();
      apb(1'b1, `SCS_ADDR_CHAN_CTRL, w, 1'b0, 32'h0);
      strb = 4'hf;
      d = {w[31:16], d[15:0]};
      apb(1'b0, `SCS_ADDR_CHAN_CTRL, 32'h0, 1'b0, d);
      repeat (3) @(posedge ref_clk);
      // Rate bit was left set by the last loop pass
      ts = d[17] ? SCS_SFD_VENDOR : (d[20] ? SCS_SFD_USER : SCS_SFD_STANDARD);
      rs = d[17] ? SCS_SFD_VENDOR : (d[21] ? SCS_SFD_USER : SCS_SFD_STANDARD);
      chk_sel("tx", tx_sel, ts, el(ts, 1'b1, ul), d[26:22]);
      chk_sel("rx", rx_sel, rs, el(rs, 1'b1, ul), d[31:27]);
      // Refused writes leave settings alone
      apb(1'b1, `SCS_ADDR_RESERVED, xs(), 1'b1, 32'h0);
      apb(1'b0, `SCS_ADDR_RESERVED, 32'h0, 1'b0, 32'h0);
      apb(1'b1, `SCS_ADDR_PATH_STATUS, 32'hffff_ffff, 1'b1, 32'h0);
      apb(1'b0, 12'h100, 32'h0, 1'b1, 32'h0);
      apb(1'b1, 12'hffc, xs(), 1'b1, 32'h0);
      apb(1'b0, `SCS_ADDR_CHAN_CTRL, 32'h0, 1'b0, d);
      apb(1'b0, `SCS_ADDR_PATH_STATUS, 32'h0, 1'b0, {26'h0, 1'b1, 1'b1, rs, ts});
      repeat (3) @(posedge ref_clk);
      final_report();
   end
endmodule
`default_nettype wire
